/* File: host_port_defines.svh */
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define BUS_WIDTH      8
`define SER_BITS       8
`define SER_DATA_PIN   7
`define SER_CLK_PIN    6
`define COM_COUNT      54
`define RD_HOLD_RESET  8'h00
`endif

/* File: host_port_pkg.sv */
package host_port_pkg;
	typedef struct packed {
		logic       is_data;
		logic [7:0] value;
	} xfer_t;
	typedef enum logic [3:0] {
		LVL_GND = 4'h1,
		LVL_V0  = 4'h2,
		LVL_V1  = 4'h4,
		LVL_V4  = 4'h8
	} com_level_t;
	typedef enum logic [2:0] {
		MODE_SERIAL = 3'b001,
		MODE_I8080  = 3'b010,
		MODE_M6800  = 3'b100
	} port_mode_t;
endpackage

/* File: sync3.sv */
`timescale 1ns/1ps
module sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	if (WIDTH < 1) begin : g_bad_width
		$error("sync3 width must be positive");
	end
	// change counts only once the last two stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q    <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	end
endmodule

/* File: com_driver.sv */
`timescale 1ns/1ps
`include "host_port_defines.svh"
module com_driver (
	input  wire logic                   scan_bit,
	input  wire logic                   frame_polarity,
	input  wire logic                   power_save,
	output host_port_pkg::com_level_t   level
);
	wire [1:0] sel_w = {scan_bit, frame_polarity};
	// power save wins over any scan state
	assign level = power_save ? host_port_pkg::LVL_GND :
		(sel_w == 2'b11) ? host_port_pkg::LVL_GND :
		(sel_w == 2'b10) ? host_port_pkg::LVL_V0 :
		(sel_w == 2'b01) ? host_port_pkg::LVL_V1 :
		host_port_pkg::LVL_V4;
endmodule

/* File: display_driver_host_port.sv */
// Behaviour
// - interface_select high picks parallel bus, low picks serial input
// - serial: data on pin 7, clock on pin 6, pins 0-5 undriven
// - serial mode is write only, never drives read data
// - chip select inactive keeps all eight data pins undriven
// - transfers accepted only while chip select is low
// - flag high marks display data, low marks command
// - bus_family_select high gives 6800 signalling, low 8080
// - 8080: bus driven while read strobe low
// - 8080: write data taken on rising write strobe
// - 6800: read-strobe pin is active-high enable
// - 6800: write-strobe pin is direction, high read, low write
// - init_n low initialises, level sensitive
// - osc_enable high runs oscillator, low stops it
// - serial: ignore pins 0-5, strobes and bus family
// - 54 common outputs from scan bit and frame polarity, ground in save
// - serial bits taken on rising clock, msb first, byte on eighth
// - serial flag sampled on every eighth rising clock edge
// - chip select inactive clears serial shifter and bit counter
`timescale 1ns/1ps
`include "host_port_defines.svh"
module display_driver_host_port #(
	parameter int BUS_W = `BUS_WIDTH,
	parameter int COMS  = `COM_COUNT
) (
	input  wire logic                      ref_clk,
	input  wire logic                      arst_n,
	input  wire logic                      ser_clk,
	input  wire logic                      interface_select,
	input  wire logic                      bus_family_select,
	input  wire logic                      chip_sel_n,
	input  wire logic                      data_command_flag,
	input  wire logic                      rd_strobe,
	input  wire logic                      wr_strobe,
	input  wire logic                      init_n,
	input  wire logic                      osc_enable,
	input  wire logic [BUS_W-1:0]          data_in,
	output logic      [BUS_W-1:0]          data_out,
	output logic      [BUS_W-1:0]          data_oe,
	input  wire logic [BUS_W-1:0]          read_data,
	output logic                           read_req,
	output host_port_pkg::xfer_t           xfer,
	output logic                           xfer_valid,
	output logic                           osc_run,
	input  wire logic [COMS-1:0]           scan_data,
	input  wire logic                      frame_polarity,
	input  wire logic                      power_save,
	output host_port_pkg::com_level_t [COMS-1:0] common_outputs
);
	// byte regs are eight bits wide and the shifter seven, nothing else fits
	if (BUS_W != 8) begin : g_bad_bus
		$error("bus width must be 8");
	end
	if (COMS < 1) begin : g_bad_coms
		$error("need at least one common output");
	end

	// init_n is level sensitive, folded into the asynchronous reset
	wire rst_n_w = arst_n & init_n;

	// pin inputs into ref_clk domain
	logic [6:0] pins_s;
	sync3 #(.WIDTH(7)) u_sync (
		.clk   (ref_clk),
		.rst_n (rst_n_w),
		.d     ({interface_select, bus_family_select, ~chip_sel_n,
			data_command_flag, rd_strobe, wr_strobe, osc_enable}),
		.q     (pins_s)
	);
	wire par_s   = pins_s[6];
	wire fam_s   = pins_s[5];
	wire cs_s    = pins_s[4];
	wire flag_s  = pins_s[3];
	wire rd_s    = pins_s[2];
	wire wr_s    = pins_s[1];
	wire osc_s   = pins_s[0];

	logic rd_d_r;
	logic wr_d_r;
	logic ser_tog_d_r;
	logic [BUS_W-1:0] rd_hold_r;

	// mode selection
	host_port_pkg::port_mode_t mode_w;
	assign mode_w = !par_s ? host_port_pkg::MODE_SERIAL :
		fam_s ? host_port_pkg::MODE_M6800 : host_port_pkg::MODE_I8080;
	wire is_8080_w = (mode_w == host_port_pkg::MODE_I8080);
	wire is_6800_w = (mode_w == host_port_pkg::MODE_M6800);

	// 8080 strobes active low
	wire w8080_w = is_8080_w & cs_s & wr_s & ~wr_d_r;
	wire r8080_w = is_8080_w & cs_s & ~rd_s;
	// 6800: rd pin is enable, wr pin is direction
	wire w6800_w = is_6800_w & cs_s & ~rd_s & rd_d_r & ~wr_s;
	wire r6800_w = is_6800_w & cs_s & rd_s & wr_s;
	wire rd_drive_w = r8080_w | r6800_w;
	// read edge ends the cycle; with flag high it reloads the holding register
	wire rd_end_w = cs_s & ((is_8080_w & rd_s & ~rd_d_r) |
		(is_6800_w & wr_s & ~rd_s & rd_d_r));

	// serial link domain
	logic [2:0] bit_cnt_r;
	logic [6:0] shift_r;
	logic [7:0] ser_byte_r;
	logic       ser_flag_r;
	logic       ser_tog_r;
	wire ser_rst_n_w = rst_n_w & ~chip_sel_n & ~interface_select;
	// only pin 7 and the link clock matter here
	wire sdi_w = data_in[`SER_DATA_PIN];
	// serial clock is pin 6, routed as its own clock port
	always_ff @(posedge ser_clk or negedge ser_rst_n_w) begin
		if (!ser_rst_n_w) begin
			bit_cnt_r <= 3'h0;
			shift_r   <= 7'h00;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			shift_r   <= {shift_r[5:0], sdi_w}; // msb first
		end
	end
	// result regs survive chip select so the byte reaches ref_clk
	always_ff @(posedge ser_clk or negedge rst_n_w) begin
		if (!rst_n_w) begin
			ser_byte_r <= 8'h00;
			ser_flag_r <= 1'b0;
			ser_tog_r  <= 1'b0;
		end else if (ser_rst_n_w && bit_cnt_r == 3'h7) begin
			ser_byte_r <= {shift_r, sdi_w};
			ser_flag_r <= data_command_flag;
			ser_tog_r  <= ~ser_tog_r;
		end
	end
	// toggle crossing; byte regs stable long before toggle seen
	logic tog_s;
	sync3 #(.WIDTH(1)) u_tog (
		.clk   (ref_clk),
		.rst_n (rst_n_w),
		.d     (ser_tog_r),
		.q     (tog_s)
	);
	wire ser_evt_w = (mode_w == host_port_pkg::MODE_SERIAL) &
		(tog_s ^ ser_tog_d_r);

	// parallel bus sampled a cycle late; strobe edge seen after sync
	logic [BUS_W-1:0] bus_s;
	sync3 #(.WIDTH(BUS_W)) u_bus (
		.clk   (ref_clk),
		.rst_n (rst_n_w),
		.d     (data_in),
		.q     (bus_s)
	);
	logic [BUS_W-1:0] bus_d_r;
	logic             flag_d_r;

	always_ff @(posedge ref_clk or negedge rst_n_w) begin
		if (!rst_n_w) begin
			rd_d_r      <= 1'b1;
			wr_d_r      <= 1'b1;
			ser_tog_d_r <= 1'b0;
			bus_d_r     <= `RD_HOLD_RESET;
			flag_d_r    <= 1'b0;
		end else begin
			rd_d_r      <= rd_s;
			wr_d_r      <= wr_s;
			ser_tog_d_r <= tog_s;
			bus_d_r     <= bus_s;
			flag_d_r    <= flag_s;
		end
	end

	// transfers only under chip select; flag types them
	wire par_wr_w = w8080_w | w6800_w;
	host_port_pkg::xfer_t xfer_nxt;
	assign xfer_nxt = ser_evt_w ?
		host_port_pkg::xfer_t'{is_data: ser_flag_r, value: ser_byte_r} :
		host_port_pkg::xfer_t'{is_data: flag_d_r, value: bus_d_r};
	always_ff @(posedge ref_clk or negedge rst_n_w) begin
		if (!rst_n_w) begin
			xfer       <= '0;
			xfer_valid <= 1'b0;
		end else begin
			xfer_valid <= ser_evt_w | par_wr_w;
			if (ser_evt_w || par_wr_w) begin
				xfer <= xfer_nxt;
			end
		end
	end

	// holding register: a read returns the word fetched before
	always_ff @(posedge ref_clk or negedge rst_n_w) begin
		if (!rst_n_w) begin
			rd_hold_r <= `RD_HOLD_RESET;
			read_req  <= 1'b0;
		end else begin
			read_req <= rd_end_w & flag_s;
			if (rd_end_w && flag_s) begin
				rd_hold_r <= read_data;
			end
		end
	end

	// serial never drives; idle chip select floats all pins
	always_ff @(posedge ref_clk or negedge rst_n_w) begin
		if (!rst_n_w) begin
			data_out <= '0;
			data_oe  <= '0;
		end else begin
			data_out <= rd_hold_r;
			data_oe  <= {BUS_W{rd_drive_w}};
		end
	end

	// oscillator enable follows its pin
	always_ff @(posedge ref_clk or negedge rst_n_w) begin
		if (!rst_n_w) begin
			osc_run <= 1'b0;
		end else begin
			osc_run <= osc_s;
		end
	end

	// one level selector per common line
	for (genvar g = 0; g < COMS; g++) begin : g_com
		com_driver u_com (
			.scan_bit       (scan_data[g]),
			.frame_polarity (frame_polarity),
			.power_save     (power_save),
			.level          (common_outputs[g])
		);
	end
endmodule

/* File: host_port_assertions.sv */
`timescale 1ns/1ps
module host_port_assertions #(
	parameter int BUS_W = 8,
	parameter int COMS  = 54
) (
	input wire logic             ref_clk,
	input wire logic             arst_n,
	input wire logic             init_n,
	input wire logic             chip_sel_n,
	input wire logic             interface_select,
	input wire logic             bus_family_select,
	input wire logic             rd_strobe,
	input wire logic             wr_strobe,
	input wire logic             osc_enable,
	input wire logic             power_save,
	input wire logic             frame_polarity,
	input wire logic [COMS-1:0]  scan_data,
	input wire logic             osc_run,
	input wire logic             xfer_valid,
	input wire logic [BUS_W-1:0] data_oe,
	input wire host_port_pkg::com_level_t [COMS-1:0] common_outputs
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// eight cycles cover the pin synchroniser and output lag
	wire logic par_rd = !chip_sel_n && interface_select &&
		(bus_family_select ? rd_strobe && wr_strobe : !rd_strobe);
	wire logic ser = !interface_select;
	wire logic s = scan_data[0];
	wire logic t = scan_data[COMS-1];
	wire host_port_pkg::com_level_t exp_last =
		(power_save || t && frame_polarity) ? host_port_pkg::LVL_GND
		: t ? host_port_pkg::LVL_V0
		: frame_polarity ? host_port_pkg::LVL_V1 : host_port_pkg::LVL_V4;
	wire host_port_pkg::com_level_t exp0 = (power_save || s && frame_polarity)
		? host_port_pkg::LVL_GND : s ? host_port_pkg::LVL_V0
		: frame_polarity ? host_port_pkg::LVL_V1 : host_port_pkg::LVL_V4;
	cs_hiz_a: assert property (chip_sel_n [*8] |-> data_oe == '0)
		else $error("bus driven while deselected");
	ser_hiz_a: assert property (ser [*8] |-> data_oe == '0)
		else $error("bus driven in serial mode");
	rd_drive_a: assert property (par_rd [*8] |-> data_oe == '1)
		else $error("bus not driven during read");
	cs_refuse_a: assert property (chip_sel_n [*8] |-> !xfer_valid)
		else $error("transfer while deselected");
	vld_pulse_a: assert property (xfer_valid |=> !xfer_valid)
		else $error("transfer strobe too long");
	init_clear_a: assert property (!init_n |-> !xfer_valid && !osc_run)
		else $error("outputs active during init");
	osc_run_a: assert property ((init_n && osc_enable) [*8] |-> osc_run)
		else $error("oscillator not running");
	com_map_a: assert property (common_outputs[0] == exp0)
		else $error("common level wrong");
	com_last_a: assert property (common_outputs[COMS-1] == exp_last)
		else $error("last common level wrong");
endmodule
bind display_driver_host_port host_port_assertions #(.BUS_W(BUS_W),
	.COMS(COMS)) i_host_port_assertions (.*);

/* File: host_model.sv */
`timescale 1ns/1ps
module host_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] data_out,
	input  wire logic [7:0] data_oe,
	output logic            ser_clk,
	output logic            interface_select,
	output logic            bus_family_select,
	output logic            chip_sel_n,
	output logic            data_command_flag,
	output logic            rd_strobe,
	output logic            wr_strobe,
	output logic [7:0]      data_in
);
	initial begin
		{ser_clk, interface_select, bus_family_select} = 3'b010;
		{chip_sel_n, data_command_flag, rd_strobe, wr_strobe} = 4'hb;
		data_in = 8'h00;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	// strobes held ten cycles so the synchroniser never misses them
	task automatic par(input logic m, rd, f, cs_n, input logic [7:0] v,
		output logic [7:0] q);
		interface_select = 1'b1;
		bus_family_select = m;
		// idle strobes of the new family settle before select drops
		rd_strobe = !m;
		wr_strobe = 1'b1;
		cyc(2);
		data_command_flag = f;
		data_in = v;
		chip_sel_n = cs_n;
		cyc(2);
		rd_strobe = m || !rd;
		wr_strobe = rd;
		cyc(10);
		// an undriven bus reads inverted so a missing drive shows
		q = (data_oe == 8'hff) ? data_out : ~data_out;
		rd_strobe = !m;
		wr_strobe = rd || !m;
		cyc(6);
		wr_strobe = 1'b1;
		chip_sel_n = 1'b1;
		data_in = ~v;
		cyc(8);
	endtask
	task automatic ser(input logic f, input logic [7:0] v, input int n,
		input logic last);
		interface_select = 1'b0;
		chip_sel_n = 1'b0;
		data_command_flag = f;
		for (int i = 7; i > 7 - n; i--) begin
			data_in = {v[i], 1'b0, ~data_in[5:0]};
			{rd_strobe, wr_strobe, bus_family_select} = data_in[2:0];
			#6 ser_clk = 1'b1;
			#6 ser_clk = 1'b0;
		end
		cyc(3);
		data_in[7] = ~data_in[7];
		chip_sel_n = last;
		cyc(9);
	endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic             ref_clk, arst_n, init_n, osc_enable, power_save;
	logic             frame_polarity;
	logic [53:0]      scan_data;
	logic [7:0]       read_data, q;
	wire logic        ser_clk, interface_select, chip_sel_n, read_req;
	wire logic        bus_family_select, data_command_flag, osc_run;
	wire logic        rd_strobe, wr_strobe, xfer_valid;
	wire logic [7:0]  data_in, data_out, data_oe;
	int               bad_count = 0, total_checks = 0, n_got = 0, cycles = 0;
	int               n_req = 0;

	host_port_pkg::xfer_t             xfer, got;
	host_port_pkg::com_level_t [53:0] common_outputs;

	display_driver_host_port i_display_driver_host_port (.*);
	host_model               i_host_model (.*);
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (xfer_valid === 1'b1) begin
			got <= xfer;
			n_got <= n_got + 1;
		end
		if (read_req === 1'b1) begin
			n_req <= n_req + 1;
		end
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
	end
	task automatic results();
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [8:0] act, exp);
		total_checks++;
		if (act !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h vs %h", $time, act, exp);
		end
	endtask
	task automatic t_write();
		int k;
		for (int i = 0; i < 4; i++) begin
			k = n_got;
			i_host_model.par(i[1], 1'b0, i[0], 1'b0, 8'h3c ^ 8'(i), q);
			check(9'(n_got - k), 9'h001);
			check(got, {i[0], 8'h3c ^ 8'(i)});
		end
		k = n_got;
		i_host_model.par(1'b0, 1'b0, 1'b1, 1'b1, 8'h55, q);
		check(9'(n_got - k), 9'h000);
	endtask
	// the first read only primes the holding register
	task automatic t_read();
		int k;
		int r;
		k = n_got;
		r = n_req;
		read_data = 8'h5a;
		i_host_model.par(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, q);
		read_data = 8'hc3;
		i_host_model.par(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, q);
		check({1'b0, q}, 9'h05a);
		read_data = 8'h0f;
		i_host_model.par(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, q);
		check({1'b0, q}, 9'h0c3);
		check(9'(n_got - k), 9'h000);
		check(9'(n_req - r), 9'h003);
	endtask
	task automatic t_serial();
		int k;
		k = n_got;
		i_host_model.ser(1'b1, 8'ha5, 8, 1'b0);
		check(got, 9'h1a5);
		i_host_model.ser(1'b0, 8'h3c, 8, 1'b1);
		check(got, 9'h03c);
		i_host_model.ser(1'b1, 8'hff, 3, 1'b1);
		i_host_model.ser(1'b1, 8'h81, 8, 1'b1);
		check(got, 9'h181);
		check(9'(n_got - k), 9'h003);
	endtask
	task automatic t_misc();
		for (int i = 0; i < 8; i++) begin
			power_save     = i[2];
			frame_polarity = i[0];
			scan_data      = {~i[1], 52'h0, i[1]};
			i_host_model.cyc(1);
		end
		osc_enable = 1'b0;
		i_host_model.cyc(10);
		check({8'h00, osc_run}, 9'h000);
		osc_enable = 1'b1;
		init_n = 1'b0;
		i_host_model.cyc(3);
		check({8'h00, osc_run}, 9'h000);
		init_n = 1'b1;
		i_host_model.cyc(10);
		check({8'h00, osc_run}, 9'h001);
	endtask
	initial begin
		{arst_n, init_n, osc_enable, frame_polarity, power_save} = 5'b01100;
		scan_data = '0;
		read_data = 8'h00;
		repeat (4) @(posedge ref_clk);
		#2 arst_n = 1'b1;
		i_host_model.cyc(6);
		t_write();
		t_read();
		t_serial();
		t_misc();
		results();
	end
endmodule
